// file: shared/bmcr_pkg.sv
package bmcr_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_ADDR_HIGH = 12'h220;
  localparam logic [11:0] OFS_ADDR_LOW  = 12'h224;
  localparam logic [11:0] OFS_BIT_MASK  = 12'h228;
  localparam logic [11:0] OFS_COMPARE   = 12'h22c;
  localparam logic [11:0] OFS_SWAP      = 12'h230;
  localparam logic [11:0] OFS_MCTRL     = 12'h234;

  // bus_master_control field positions
  localparam int POS_QUIESCE_ACK = 27;
  localparam int POS_QUIESCE_REQ = 26;
  localparam int POS_HOLD_GRANT  = 25;
  localparam int POS_HOLD_REQ    = 24;
  localparam int POS_RMW_ENABLE  = 20;
  localparam int POS_A64_BOTH_DS = 16;
  localparam int POS_TIME_OFF    = 12;
  localparam int POS_TIME_ON     = 8;
  localparam int POS_RELEASE     = 3;
  localparam int POS_FAIR        = 2;
  localparam int POS_LEVEL       = 0;

  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [1:0]  RST_LEVEL = 2'h3;

  // release policy codes
  localparam logic [1:0] REL_ON_OR_DONE      = 2'h0;
  localparam logic [1:0] REL_ON_REQ_OR_DONE  = 2'h1;
  localparam logic [1:0] REL_ON_BCLR_OR_DONE = 2'h2;
  localparam logic [1:0] REL_ON_DONE_AND_REQ = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TIME_ON_MAX_US = 512;
  localparam int TIME_OFF_MAX_US = 64;
  localparam int TIME_ON_MAX_CYC = TIME_ON_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int TIME_OFF_MAX_CYC = TIME_OFF_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int TIME_ON_MIN_BYTES = 128;
  localparam logic [12:0] BYTES_PER_BEAT = 13'h008;

  typedef struct packed {
    logic       quiesce_request;
    logic       bus_hold_request;
    logic       rmw_enable_bit;
    logic       wide_addr_both_strobes;
    logic [2:0] master_time_off;
    logic [2:0] master_time_on;
    logic [1:0] release_policy;
    logic       fair_request_mode;
    logic [1:0] request_level;
  } bmcr_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_OWN,
    ST_RMW_RD,
    ST_RMW_WR,
    ST_OFF
  } bmcr_state_t;

endpackage

// file: design/bmcr_top.sv
`timescale 1ns/1ps
// Overview of operation
// - register holds trigger address bits 63:32, read and write.
// - register holds trigger address bits 31:2, read and write.
// - bit mask picks which data bits join compare and swap.
// - enabled bits of read data are compared with compare value.
// - enabled swap bits are written back only on a successful compare.
// - read-modify-write cycles are armed only while control bit 20 is set.
// - throttling applies to channel and DMA cycles, not to read-modify-write.
// - quiesce bit 26 requests bus, sets bit 27, holds until cleared.
// - quiesce blocks the PCI/X channel and DMA from the bus.
// - local reset input clears the quiesce bit and releases the bus.
// - quiesce acknowledge only for ownership gained through quiesce.
// - hold bit 24 requests bus, sets bit 25, holds until cleared.
// - under hold the channel and DMA may still use the bus.
// - bit 16 asserts both strobes in A64 address phase.
// - wait time-off 0, 1 up to 64 us before re-requesting.
// - single and block transfers limit time on from 4 to 512 us.
// - 2e transfers limit time on in bytes, 128 up to 4096.
// - after time-on is used up, access again only after time-off.
// - release by field 4:3 from time-on, done, request, bus clear.
// - bit 2 selects fair or normal requester mode.
// - request drives the level chosen by field 1:0, reset 11b.
module bmcr_top
  import bmcr_pkg::*;
#(
  parameter int TON_MAX_CYC = TIME_ON_MAX_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic        PCI_WR,
  input  wire logic [63:0] PCI_ADDR,
  input  wire logic        CH_REQ,
  input  wire logic        DMA_REQ,
  input  wire logic        XFER_2E,
  input  wire logic        XFER_BEAT,
  output logic             CH_GRANT,
  output logic             DMA_GRANT,
  input  wire logic        BUS_GRANT_IN,
  input  wire logic        BUS_CLEAR_IN,
  input  wire logic [3:0]  BUS_REQ_IN,
  input  wire logic        LOCAL_RESET_IN_N,
  input  wire logic        VME_ACK,
  input  wire logic [31:0] VME_RDATA,
  output logic      [3:0]  BUS_REQ,
  output logic             BUS_BUSY,
  output logic             VME_RD,
  output logic             VME_WR,
  output logic      [31:0] VME_WDATA,
  output logic             RMW_DONE,
  output logic             RMW_MATCH,
  output logic             WIDE_ADDR_BOTH_STROBES
);

  bmcr_ctrl_t  ctrl_q;
  bmcr_state_t state_q, state_d;
  logic [31:0] addr_high_q, mask_q, compare_q, swap_q, rd_data_q;
  logic [29:0] addr_low_q;
  logic [7:0]  sync1_q, sync2_q;
  logic        grant_s, bclr_s, ack_s, lrst_s;
  logic [3:0]  other_s;
  logic [15:0] cnt_q;
  logic [12:0] bytes_q;
  logic        rmw_pend_q, own_by_q_q, own_by_h_q, qack_q, hack_q;
  logic        other_lvl, ton_exp, done, keep, pol_ok, release_now, want;
  logic        eff_ch, eff_dma, eff_rmw, rmw_hit, match_now;
  logic [31:0] merged;

  function automatic logic [3:0] onehot(input logic [1:0] lvl);
    onehot = 4'h1 << lvl;
  endfunction

  function automatic logic [15:0] ton_cycles(input logic [2:0] code);
    ton_cycles = 16'(TON_MAX_CYC >> (3'h7 - code));
  endfunction

  function automatic logic [15:0] toff_cycles(input logic [2:0] code);
    if (code == 3'h0) begin
      toff_cycles = 16'h0000;
    end else begin
      toff_cycles = 16'(TIME_OFF_MAX_CYC >> (3'h7 - code));
    end
  endfunction

  function automatic logic [12:0] ton_bytes(input logic [2:0] code);
    if (code <= 3'h2) begin
      ton_bytes = 13'(TIME_ON_MIN_BYTES);
    end else begin
      ton_bytes = 13'(TIME_ON_MIN_BYTES << (code - 3'h2));
    end
  endfunction

  // two-stage synchronisers for backplane inputs
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= {BUS_REQ_IN, ~LOCAL_RESET_IN_N, VME_ACK, BUS_CLEAR_IN,
                  BUS_GRANT_IN};
      sync2_q <= sync1_q;
    end
  end

  assign grant_s = sync2_q[0];
  assign bclr_s  = sync2_q[1];
  assign ack_s   = sync2_q[2];
  assign lrst_s  = sync2_q[3];
  assign other_s = sync2_q[7:4];

  assign eff_ch  = CH_REQ & ~ctrl_q.quiesce_request;
  assign eff_dma = DMA_REQ & ~ctrl_q.quiesce_request;
  assign eff_rmw = rmw_pend_q & ~ctrl_q.quiesce_request;
  assign want    = ctrl_q.quiesce_request | ctrl_q.bus_hold_request |
                   eff_ch | eff_dma | eff_rmw;
  assign other_lvl = other_s[ctrl_q.request_level];

  assign ton_exp = XFER_2E ? (bytes_q >= ton_bytes(ctrl_q.master_time_on))
                           : (cnt_q >= ton_cycles(ctrl_q.master_time_on));
  assign done = ~eff_ch & ~eff_dma & ~eff_rmw;
  // ownership kept for quiesce or hold
  assign keep = (own_by_q_q & ctrl_q.quiesce_request) |
                (own_by_h_q & ctrl_q.bus_hold_request);

  always_comb begin
    case (ctrl_q.release_policy)
      REL_ON_OR_DONE:      pol_ok = ton_exp | done;
      REL_ON_REQ_OR_DONE:  pol_ok = (ton_exp & |other_s) | done;
      REL_ON_BCLR_OR_DONE: pol_ok = (ton_exp & bclr_s) | done;
      REL_ON_DONE_AND_REQ: pol_ok = (ton_exp | done) & |other_s;
      default:             pol_ok = 1'b0;
    endcase
  end
  assign release_now = ~keep & pol_ok;

  // masked compare, merge keeps unmasked read bits
  assign match_now = (((VME_RDATA ^ compare_q) & mask_q) == 32'h0000_0000);
  assign merged    = (rd_data_q & ~mask_q) | (swap_q & mask_q);

  // trigger address match only while enabled
  assign rmw_hit = PCI_WR & ctrl_q.rmw_enable_bit & ~rmw_pend_q &
                   (PCI_ADDR[63:32] == addr_high_q) &
                   (PCI_ADDR[31:2] == addr_low_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (want && !(ctrl_q.fair_request_mode && other_lvl)) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (grant_s) begin
          state_d = ST_OWN;
        end
      end
      ST_OWN: begin
        // read and write under one tenure
        if (eff_rmw && !ack_s) begin
          state_d = ST_RMW_RD;
        end else if (release_now) begin
          state_d = ST_OFF;
        end
      end
      ST_RMW_RD: begin
        if (ack_s && VME_RD) begin
          state_d = match_now ? ST_RMW_WR : ST_OWN;
        end
      end
      ST_RMW_WR: begin
        if (ack_s && VME_WR) begin
          state_d = ST_OWN;
        end
      end
      ST_OFF: begin
        if (cnt_q >= toff_cycles(ctrl_q.master_time_off)) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (lrst_s) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q   <= 16'h0000;
      bytes_q <= 13'h0000;
    end else if (state_d != state_q) begin
      cnt_q   <= 16'h0000;
      bytes_q <= 13'h0000;
    end else begin
      if (cnt_q != 16'hffff) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      if (XFER_BEAT && (bytes_q < 13'h1ff8)) begin
        bytes_q <= bytes_q + BYTES_PER_BEAT;
      end
    end
  end

  // ownership cause, acknowledge tied to quiesce tenure
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      own_by_q_q <= 1'b0;
      own_by_h_q <= 1'b0;
    end else if (state_q == ST_REQ && state_d == ST_OWN) begin
      own_by_q_q <= ctrl_q.quiesce_request;
      own_by_h_q <= ctrl_q.bus_hold_request;
    end else if (state_d == ST_IDLE || state_d == ST_OFF) begin
      own_by_q_q <= 1'b0;
      own_by_h_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      qack_q <= 1'b0;
      hack_q <= 1'b0;
    end else begin
      // local reset drops the flag with the tenure, not a cycle later
      qack_q <= own_by_q_q & ctrl_q.quiesce_request & BUS_BUSY & ~lrst_s;
      hack_q <= own_by_h_q & ctrl_q.bus_hold_request & BUS_BUSY;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      BUS_REQ  <= 4'h0;
      BUS_BUSY <= 1'b0;
    end else begin
      BUS_REQ  <= (state_d == ST_REQ) ? onehot(ctrl_q.request_level) : 4'h0;
      BUS_BUSY <= (state_d == ST_OWN) || (state_d == ST_RMW_RD) ||
                  (state_d == ST_RMW_WR);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CH_GRANT  <= 1'b0;
      DMA_GRANT <= 1'b0;
    end else begin
      CH_GRANT  <= (state_q == ST_OWN) && (state_d == ST_OWN) &&
                   eff_ch && !ton_exp;
      DMA_GRANT <= (state_q == ST_OWN) && (state_d == ST_OWN) &&
                   eff_dma && !eff_ch && !ton_exp;
    end
  end

  // data strobes held until acknowledge
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      VME_RD    <= 1'b0;
      VME_WR    <= 1'b0;
      VME_WDATA <= 32'h0000_0000;
      rd_data_q <= 32'h0000_0000;
    end else begin
      VME_RD <= (state_d == ST_RMW_RD) && !(ack_s && VME_RD);
      VME_WR <= (state_d == ST_RMW_WR) && (VME_WR || !ack_s) &&
                !(ack_s && VME_WR);
      if (state_q == ST_RMW_RD && ack_s && VME_RD) begin
        rd_data_q <= VME_RDATA;
      end
      if (state_q == ST_RMW_WR) begin
        VME_WDATA <= merged;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rmw_pend_q <= 1'b0;
      RMW_DONE   <= 1'b0;
      RMW_MATCH  <= 1'b0;
    end else begin
      RMW_DONE <= 1'b0;
      if (rmw_hit) begin
        rmw_pend_q <= 1'b1;
      end
      if (state_q == ST_RMW_RD && ack_s && VME_RD && !match_now) begin
        rmw_pend_q <= 1'b0;
        RMW_DONE   <= 1'b1;
        RMW_MATCH  <= 1'b0;
      end
      if (state_q == ST_RMW_WR && ack_s && VME_WR) begin
        rmw_pend_q <= 1'b0;
        RMW_DONE   <= 1'b1;
        RMW_MATCH  <= 1'b1;
      end
    end
  end

  // register writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_high_q <= RST_WORD;
      addr_low_q  <= RST_WORD[31:2];
      mask_q      <= RST_WORD;
      compare_q   <= RST_WORD;
      swap_q      <= RST_WORD;
    end else if (REG_WR) begin
      case (REG_ADDR)
        OFS_ADDR_HIGH: addr_high_q <= REG_WDATA;
        OFS_ADDR_LOW:  addr_low_q  <= REG_WDATA[31:2];
        OFS_BIT_MASK:  mask_q      <= REG_WDATA;
        OFS_COMPARE:   compare_q   <= REG_WDATA;
        OFS_SWAP:      swap_q      <= REG_WDATA;
        default:       ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q               <= '0;
      ctrl_q.request_level <= RST_LEVEL;
    end else begin
      if (REG_WR && REG_ADDR == OFS_MCTRL) begin
        ctrl_q.quiesce_request        <= REG_WDATA[POS_QUIESCE_REQ];
        ctrl_q.bus_hold_request       <= REG_WDATA[POS_HOLD_REQ];
        ctrl_q.rmw_enable_bit         <= REG_WDATA[POS_RMW_ENABLE];
        ctrl_q.wide_addr_both_strobes <= REG_WDATA[POS_A64_BOTH_DS];
        ctrl_q.master_time_off <= REG_WDATA[POS_TIME_OFF+:3];
        ctrl_q.master_time_on  <= REG_WDATA[POS_TIME_ON+:3];
        ctrl_q.release_policy  <= REG_WDATA[POS_RELEASE+:2];
        ctrl_q.fair_request_mode <= REG_WDATA[POS_FAIR];
        ctrl_q.request_level   <= REG_WDATA[POS_LEVEL+:2];
      end
      if (lrst_s) begin
        ctrl_q.quiesce_request <= 1'b0;
      end
    end
  end

  // strobe mode for A64 address phase
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      WIDE_ADDR_BOTH_STROBES <= 1'b0;
    end else begin
      WIDE_ADDR_BOTH_STROBES <= ctrl_q.wide_addr_both_strobes;
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      REG_RDATA <= 32'h0000_0000;
      if (REG_RD) begin
        case (REG_ADDR)
          OFS_ADDR_HIGH: REG_RDATA <= addr_high_q;
          OFS_ADDR_LOW:  REG_RDATA <= {addr_low_q, 2'h0};
          OFS_BIT_MASK:  REG_RDATA <= mask_q;
          OFS_COMPARE:   REG_RDATA <= compare_q;
          OFS_SWAP:      REG_RDATA <= swap_q;
          OFS_MCTRL: begin
            REG_RDATA[POS_QUIESCE_ACK] <= qack_q;
            REG_RDATA[POS_QUIESCE_REQ] <= ctrl_q.quiesce_request;
            REG_RDATA[POS_HOLD_GRANT]  <= hack_q;
            REG_RDATA[POS_HOLD_REQ]    <= ctrl_q.bus_hold_request;
            REG_RDATA[POS_RMW_ENABLE]  <= ctrl_q.rmw_enable_bit;
            REG_RDATA[POS_A64_BOTH_DS] <= ctrl_q.wide_addr_both_strobes;
            REG_RDATA[POS_TIME_OFF+:3] <= ctrl_q.master_time_off;
            REG_RDATA[POS_TIME_ON+:3]  <= ctrl_q.master_time_on;
            REG_RDATA[POS_RELEASE+:2]  <= ctrl_q.release_policy;
            REG_RDATA[POS_FAIR]        <= ctrl_q.fair_request_mode;
            REG_RDATA[POS_LEVEL+:2]    <= ctrl_q.request_level;
          end
          default: REG_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_write_ack;
    VME_WR && ack_s;
  endsequence

  sequence s_done_match;
    ##1 (RMW_DONE && RMW_MATCH);
  endsequence

  rmw_write_gate_a: assert property ($rose(VME_WR) |->
    (((rd_data_q ^ compare_q) & mask_q) == 32'h0000_0000))
    else $error("write-back without a matching compare");

  write_merge_a: assert property (s_write_ack |-> VME_WDATA == merged)
    else $error("written word not merged from read data");

  write_done_a: assert property (s_write_ack |-> s_done_match)
    else $error("successful swap not reported");

  rmw_enable_a: assert property ($rose(rmw_pend_q) |->
    $past(ctrl_q.rmw_enable_bit))
    else $error("cycle armed while function disabled");

  rmw_tenure_a: assert property ((VME_RD || VME_WR) |-> BUS_BUSY)
    else $error("read-modify-write strobe without ownership");

  quiesce_block_a: assert property ((ctrl_q.quiesce_request &&
    $past(ctrl_q.quiesce_request)) |-> !CH_GRANT && !DMA_GRANT)
    else $error("channel granted while quiesced");

  quiesce_ack_a: assert property (qack_q |-> own_by_q_q && BUS_BUSY)
    else $error("quiesce acknowledge without quiesce tenure");

  local_reset_a: assert property (lrst_s |=> !ctrl_q.quiesce_request
    ##1 !BUS_BUSY)
    else $error("local reset did not clear quiesce and release");

  hold_keep_a: assert property ((BUS_BUSY && own_by_h_q &&
    ctrl_q.bus_hold_request && !lrst_s) |=> BUS_BUSY)
    else $error("held bus released while hold requested");

  fair_wait_a: assert property (($rose(|BUS_REQ) &&
    $past(ctrl_q.fair_request_mode)) |-> !$past(other_lvl))
    else $error("fair requester raised over a pending request");

  req_level_a: assert property ((|BUS_REQ) |->
    BUS_REQ == onehot($past(ctrl_q.request_level)))
    else $error("request on wrong level");

  time_off_a: assert property ((state_q == ST_OFF) |->
    BUS_REQ == 4'h0 && !BUS_BUSY)
    else $error("bus requested during time-off");

endmodule

// file: tb/bmcr_arb_model.sv
`timescale 1ns/1ps
// arbiter and one slave word on the far side of the master
module bmcr_arb_model #(
  parameter int DLY = 3
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  bus_req,
  input  wire logic        vme_rd,
  input  wire logic        vme_wr,
  input  wire logic [31:0] vme_wdata,
  output logic             grant,
  output logic             ack,
  output logic      [31:0] rdata
);
  logic [31:0] mem_q;
  int          wait_q;

  // released data lines show the inverse, never the last word
  assign rdata = ack ? mem_q : ~mem_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      grant  <= 1'b0;
      ack    <= 1'b0;
      wait_q <= 0;
    end else begin
      grant <= |bus_req;
      if (!(vme_rd || vme_wr)) begin
        ack    <= 1'b0;
        wait_q <= 0;
      end else if (wait_q < DLY) begin
        wait_q <= wait_q + 1;
      end else begin
        ack <= 1'b1;
        if (vme_wr && !ack) mem_q <= vme_wdata;
      end
    end
  end
endmodule

// file: tb/bmcr_top_tb.sv
`timescale 1ns/1ps
module bmcr_top_tb;
  import bmcr_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end

  localparam logic [11:0] OFS_T [6] = '{OFS_ADDR_HIGH, OFS_ADDR_LOW,
    OFS_BIT_MASK, OFS_COMPARE, OFS_SWAP, OFS_MCTRL};
  logic        CLK, RESETN, REG_WR, REG_RD, PCI_WR, CH_REQ;
  logic        LOCAL_RESET_IN_N, CH_GRANT, BUS_GRANT_IN, VME_ACK;
  logic        BUS_BUSY, VME_RD, VME_WR, RMW_DONE, RMW_MATCH, WIDE_DS;
  logic [11:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, VME_RDATA, VME_WDATA, rd_q;
  logic [63:0] PCI_ADDR;
  logic [3:0]  BUS_REQ_IN, BUS_REQ;
  logic        seen, DMA_REQ, DMA_GRANT;
  int          failures = 0;
  int          n_checks = 0;

  bmcr_top #(.TON_MAX_CYC(1280)) i_bmcr_top (
    .CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PCI_WR(PCI_WR), .PCI_ADDR(PCI_ADDR), .CH_REQ(CH_REQ), .DMA_REQ(DMA_REQ),
    .XFER_2E(1'b0), .XFER_BEAT(1'b0), .CH_GRANT(CH_GRANT),
    .DMA_GRANT(DMA_GRANT), .BUS_GRANT_IN(BUS_GRANT_IN), .BUS_CLEAR_IN(1'b0),
    .BUS_REQ_IN(BUS_REQ_IN), .LOCAL_RESET_IN_N(LOCAL_RESET_IN_N),
    .VME_ACK(VME_ACK), .VME_RDATA(VME_RDATA), .BUS_REQ(BUS_REQ),
    .BUS_BUSY(BUS_BUSY), .VME_RD(VME_RD), .VME_WR(VME_WR),
    .VME_WDATA(VME_WDATA), .RMW_DONE(RMW_DONE), .RMW_MATCH(RMW_MATCH),
    .WIDE_ADDR_BOTH_STROBES(WIDE_DS));

  bmcr_arb_model i_bmcr_arb_model (
    .clk(CLK), .rstn(RESETN), .bus_req(BUS_REQ), .vme_rd(VME_RD),
    .vme_wr(VME_WR), .vme_wdata(VME_WDATA), .grant(BUS_GRANT_IN),
    .ack(VME_ACK), .rdata(VME_RDATA));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task rd(input logic [11:0] a);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 rd_q = REG_RDATA;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return BUS_BUSY;
      1: return RMW_DONE;
      3: return DMA_GRANT;
      default: return CH_GRANT;
    endcase
  endfunction

  // bounded wait on a design output, then compare it
  task automatic wait_v(input int k, input logic v, input int n);
    int i;
    for (i = 0; i < n && sig(k) !== v; i++) @(posedge CLK) #1;
    `CHK(sig(k), v)
  endtask

  // write strobe only while the bus is owned
  always @(posedge VME_WR) #1 `CHK(BUS_BUSY, 1'b1)

  task t_regs;
    for (int i = 0; i < 6; i++) begin
      rd(OFS_T[i]);
      `CHK(rd_q, i == 5 ? 32'h0000_0003 : RST_WORD)
    end
    for (int i = 0; i < 5; i++) wr(OFS_T[i], 32'ha5c3_0f1e ^ i);
    for (int i = 0; i < 5; i++) begin
      rd(OFS_T[i]);
      `CHK(rd_q, (32'ha5c3_0f1e ^ i) & (i == 1 ? 32'hffff_fffc : '1))
    end
    wr(OFS_MCTRL, 32'hfaff_ffff);
    rd(OFS_MCTRL);
    `CHK(rd_q, 32'h0011_771f)
    `CHK(WIDE_DS, 1'b1)
    rd(12'h23c);
    `CHK(rd_q, 32'h0)
    wr(OFS_MCTRL, 32'h0000_0003);
    rd(OFS_MCTRL);
    `CHK(WIDE_DS, 1'b0)
  endtask

  task t_rmw(input logic [31:0] ctl, m0, input logic hit);
    i_bmcr_arb_model.mem_q = m0;
    wr(OFS_MCTRL, ctl);
    @(posedge CLK);
    PCI_ADDR <= 64'h0000_0001_0000_1007;
    PCI_WR <= 1'b1;
    @(posedge CLK);
    PCI_WR <= 1'b0;
    seen = 1'b0;
    if (ctl[20]) begin
      wait_v(1, 1'b1, 2000);
      `CHK(RMW_MATCH, hit)
      `CHK(i_bmcr_arb_model.mem_q, hit ? 32'h5555_beef : m0)
    end else begin
      repeat (100) @(posedge CLK) seen |= VME_RD;
      `CHK(seen, 1'b0)
    end
    wait_v(0, 1'b0, 500);
  endtask

  task t_quiesce;
    wr(OFS_MCTRL, 32'h0400_0003);
    wait_v(0, 1'b1, 200);
    rd(OFS_MCTRL);
    `CHK(rd_q, 32'h0c00_0003)
    CH_REQ <= 1'b1;
    repeat (20) @(posedge CLK);
    `CHK(CH_GRANT, 1'b0)
    wr(OFS_MCTRL, 32'h0000_0003);
    wait_v(2, 1'b1, 200);
    CH_REQ <= 1'b0;
    wait_v(0, 1'b0, 500);
    // longest time-on, so grants are not cut off by the limit
    wr(OFS_MCTRL, 32'h0100_0703);
    wait_v(0, 1'b1, 200);
    rd(OFS_MCTRL);
    `CHK(rd_q, 32'h0300_0703)
    CH_REQ <= 1'b1;
    wait_v(2, 1'b1, 200);
    CH_REQ <= 1'b0;
    DMA_REQ <= 1'b1;
    wait_v(3, 1'b1, 200);
    DMA_REQ <= 1'b0;
    repeat (20) @(posedge CLK);
    `CHK(BUS_BUSY, 1'b1)
    wr(OFS_MCTRL, 32'h0400_0003);
    for (int n = 0; n < 50 && rd_q[27] !== 1'b1; n++) rd(OFS_MCTRL);
    `CHK(rd_q[27], 1'b1)
    wait_v(0, 1'b1, 200);
    LOCAL_RESET_IN_N <= 1'b0;
    repeat (4) @(posedge CLK);
    LOCAL_RESET_IN_N <= 1'b1;
    wait_v(0, 1'b0, 50);
    rd(OFS_MCTRL);
    `CHK(rd_q, 32'h0000_0003)
  endtask

  task t_level;
    int n;
    // other request passes the syncs on the same edge that fair mode is set
    BUS_REQ_IN <= 4'h2;
    wr(OFS_MCTRL, 32'h0000_1005);
    CH_REQ <= 1'b1;
    seen = 1'b0;
    repeat (30) @(posedge CLK) seen |= |BUS_REQ;
    `CHK(seen, 1'b0)
    BUS_REQ_IN <= 4'h0;
    for (n = 0; n < 20 && BUS_REQ === 4'h0; n++) @(posedge CLK) #1;
    `CHK(BUS_REQ, 4'h2)
    wait_v(2, 1'b1, 200);
    CH_REQ <= 1'b0;
    wait_v(0, 1'b0, 500);
    CH_REQ <= 1'b1;
    for (n = 0; n < 200 && BUS_REQ === 4'h0; n++) @(posedge CLK) #1;
    // one microsecond is fifty cycles
    `CHK((n > 40) && (n < 60), 1'b1)
    wait_v(2, 1'b1, 200);
    CH_REQ <= 1'b0;
    wait_v(0, 1'b0, 500);
  endtask

  task finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #300000;
    failures++;
    finish_test();
  end

  initial begin
    RESETN = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 12'h000;
    REG_WDATA = 32'h0;
    PCI_WR = 1'b0;
    PCI_ADDR = 64'h0;
    CH_REQ = 1'b0;
    DMA_REQ = 1'b0;
    BUS_REQ_IN = 4'h0;
    LOCAL_RESET_IN_N = 1'b1;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    t_regs();
    wr(OFS_ADDR_HIGH, 32'h0000_0001);
    wr(OFS_ADDR_LOW, 32'h0000_1004);
    wr(OFS_BIT_MASK, 32'h0000_ffff);
    wr(OFS_COMPARE, 32'h0000_1234);
    wr(OFS_SWAP, 32'hdead_beef);
    t_rmw(32'h0010_0003, 32'h5555_1234, 1'b1);
    t_rmw(32'h0010_0003, 32'h5555_1235, 1'b0);
    t_rmw(32'h0000_0003, 32'h5555_1234, 1'b0);
    t_quiesce();
    t_level();
    finish_test();
  end
endmodule
